// *** rtl/chi_pkg.sv ***
/*
  Shared constants and types of the charger host-control block: I2C slave map,
  status and control fields, interrupt timing and protection fold-back levels.
  Assumes one 50 MHz reference clock for every user of this package.
*/
`default_nettype none

package chi_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;
  localparam int unsigned INT_PULSE_US     = 1000;
  localparam int unsigned INT_PULSE_CYCLES = (CLK_FREQ_HZ / 1_000_000) * INT_PULSE_US;

  // ---------------------------------------------------------------
  // I2C map
  // ---------------------------------------------------------------
  localparam logic [6:0]  SLAVE_ADDR = 7'h74;
  localparam int unsigned NUM_REGS   = 8;
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_MASK   = 8'h01;
  localparam logic [7:0]  REG_CTRL   = 8'h02;
  localparam logic [7:0]  REG_RESET  = 8'h00;

  // Status and mask bit positions
  localparam int unsigned STS_CHG_DONE  = 0;
  localparam int unsigned STS_OVERHEAT  = 1;
  localparam int unsigned STS_BUS_SHORT = 2;
  localparam int unsigned STS_LOAD_A    = 3;
  localparam int unsigned STS_LOAD_B    = 4;
  localparam int unsigned STS_ADAPTER   = 5;

  // Control bit positions
  localparam int unsigned CTRL_DISCHARGE = 0;
  localparam int unsigned CTRL_OVP_OFF   = 1;
  localparam int unsigned CTRL_FOLD_OFF  = 2;

  // ---------------------------------------------------------------
  // Current limit scaling in percent of the setting
  // ---------------------------------------------------------------
  localparam logic [6:0] LIMIT_FULL_PCT = 7'h64;
  localparam logic [6:0] FOLD_BUS_PCT   = 7'h16;
  localparam logic [6:0] FOLD_BAT_PCT   = 7'h0A;

  localparam int unsigned BUF_DEPTH = 2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_REG,
    I2C_WDAT,
    I2C_RDAT
  } chi_state_e;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic bus_over;
    logic bat_over;
    logic bus_low;
    logic temp_high;
    logic temp_cool;
    logic adapter_sense_pin;
    logic charge_done;
    logic load_a;
    logic load_b;
  } chi_sense_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } chi_wr_s;

endpackage

`default_nettype wire

// *** rtl/chi_buf2.sv ***
/*
  Small FIFO with valid/ready on both sides, used as the write buffer.
  Assumes one clock; the drain side may stall at will.
*/
`default_nettype none

module chi_buf2 #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  logic             push_w;
  logic             pop_w;

  assign in_ready  = cnt_q != (PW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];
  assign push_w    = in_valid & in_ready;
  assign pop_w     = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push_w) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push_w) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
      end
      if (pop_w) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
      end
      cnt_q <= cnt_q + (PW+1)'(push_w) - (PW+1)'(pop_w);
    end
  end

  // A stalled head word must neither vanish nor change
  property p_head_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("buffer head lost while stalled");

endmodule

`default_nettype wire

// *** rtl/chi_charger_ctrl.sv ***
/*
  Host-side control of the charger: I2C slave with a small register file,
  interrupt generator, standby/shutdown control and protection gating.
  Assumes comparator levels and pins are asynchronous to ref_clk and that
  the register write stream consumer may stall.
*/
`default_nettype none

module chi_charger_ctrl #(
  parameter int unsigned PULSE_CYCLES = chi_pkg::INT_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // Mode pins
  input  wire logic                chip_enable_n,
  input  wire logic                power_stage_halt,
  // I2C pins, open drain
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  // Interrupt pin
  output logic                     int_n,
  // Comparator levels
  input  wire chi_pkg::chi_sense_s sense,
  // Register write stream
  output logic                     reg_wr_valid,
  output var chi_pkg::chi_wr_s     reg_wr,
  input  wire logic                reg_wr_ready,
  // Power stage control
  output logic                     switch_enable,
  output logic                     standby,
  output logic                     shutdown,
  output logic                     discharge_enable,
  output logic [6:0]               bus_current_limit_pct,
  output logic [6:0]               battery_current_limit_pct
);
  import chi_pkg::*;

  localparam int unsigned NS = $bits(chi_sense_s);
  localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);
  localparam int unsigned IW = $clog2(NUM_REGS);
  localparam logic [NS+3:0] SYNC_RST = {4'hE, {NS{1'b0}}};
  // Adapter, overheat and charge done react to both edges
  localparam logic [4:0] BOTH_EDGES = 5'h13;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  function automatic logic addr_ok(input logic [7:0] a);
    return a < 8'(NUM_REGS);
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NS+3:0] sync1_q;
  logic [NS+3:0] sync2_q;
  logic          scl_s;
  logic          sda_s;
  logic          ce_n_s;
  logic          halt_s;
  chi_sense_s    sns;

  // SCL is sampled as data; 50 MHz gives ample margin at 400 kHz
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= {scl_in, sda_in, chip_enable_n, power_stage_halt, sense};
      sync2_q <= sync1_q;
    end
  end

  assign {scl_s, sda_s, ce_n_s, halt_s, sns} = sync2_q;

  // ---------------------------------------------------------------
  // Bus conditions
  // ---------------------------------------------------------------
  logic scl_d_q;
  logic sda_d_q;
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise_w = scl_s & ~scl_d_q;
  assign scl_fall_w = ~scl_s & scl_d_q;
  assign start_w    = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_w     = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] mask_w;
  logic [7:0] ctrl_w;
  logic [7:0] status_w;
  logic       wr_fire_w;

  assign mask_w    = regs_q[REG_MASK[IW-1:0]];
  assign ctrl_w    = regs_q[REG_CTRL[IW-1:0]];
  assign wr_fire_w = reg_wr_valid & reg_wr_ready;

  // Status is not storage; writes to its address are dropped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (wr_fire_w && reg_wr.addr != REG_STATUS && addr_ok(reg_wr.addr)) begin
      regs_q[reg_wr.addr[IW-1:0]] <= reg_wr.data;
    end
  end

  // ---------------------------------------------------------------
  // Protection and modes
  // ---------------------------------------------------------------
  logic       discharge_w;
  logic       bus_ovp_w;
  logic       short_w;
  logic       overheat_q;
  logic       switch_d;
  logic       fold_w;
  logic       switch_q;
  logic       standby_q;
  logic       shutdown_q;
  logic [6:0] bus_pct_q;
  logic [6:0] bat_pct_q;

  assign discharge_w = ctrl_w[CTRL_DISCHARGE];
  assign bus_ovp_w   = discharge_w & ~ctrl_w[CTRL_OVP_OFF] & sns.bus_over;
  assign short_w     = discharge_w & sns.bus_low;
  assign fold_w      = short_w & ~ctrl_w[CTRL_FOLD_OFF];
  // Battery overvoltage applies whatever the mode
  assign switch_d    = ~ce_n_s & ~halt_s & ~bus_ovp_w & ~sns.bat_over & ~overheat_q;

  // Hot wins over cool, so a noisy pair keeps the stage off
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      overheat_q <= 1'b0;
    end else begin
      overheat_q <= sns.temp_high | (overheat_q & ~sns.temp_cool);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_q   <= 1'b0;
      standby_q  <= 1'b0;
      shutdown_q <= 1'b1;
      bus_pct_q  <= LIMIT_FULL_PCT;
      bat_pct_q  <= LIMIT_FULL_PCT;
    end else begin
      switch_q   <= switch_d;
      standby_q  <= ~ce_n_s & halt_s;
      shutdown_q <= ce_n_s;
      bus_pct_q  <= fold_w ? FOLD_BUS_PCT : LIMIT_FULL_PCT;
      bat_pct_q  <= fold_w ? FOLD_BAT_PCT : LIMIT_FULL_PCT;
    end
  end

  assign switch_enable             = switch_q;
  assign standby                   = standby_q;
  assign shutdown                  = shutdown_q;
  assign discharge_enable          = discharge_w;
  assign bus_current_limit_pct     = bus_pct_q;
  assign battery_current_limit_pct = bat_pct_q;

  // ---------------------------------------------------------------
  // Status flags and interrupt
  // ---------------------------------------------------------------
  logic [4:0]    ev_now_w;
  logic [4:0]    ev_prev_q;
  logic [4:0]    ev_edge_w;
  logic [4:0]    ev_mask_w;
  logic          evt_w;
  logic [1:0]    loads_q;
  logic          status_clr_w;
  logic          short_int_w;
  logic [CW-1:0] int_cnt_q;
  logic [CW-1:0] int_cnt_d;
  logic          int_n_q;

  assign ev_now_w  = {sns.adapter_sense_pin, sns.load_b, sns.load_a, overheat_q, sns.charge_done};
  // Load inputs only count their rising edge
  assign ev_edge_w = (ev_now_w ^ ev_prev_q) & (ev_now_w | BOTH_EDGES);
  assign ev_mask_w = {mask_w[STS_ADAPTER], mask_w[STS_LOAD_B], mask_w[STS_LOAD_A],
                      mask_w[STS_OVERHEAT], mask_w[STS_CHG_DONE]};
  assign evt_w       = |(ev_edge_w & ~ev_mask_w);
  assign short_int_w = short_w & ~mask_w[STS_BUS_SHORT];
  assign int_cnt_d   = evt_w ? CW'(PULSE_CYCLES) :
                       (int_cnt_q != '0) ? int_cnt_q - CW'(1) : '0;

  // Live flags pass straight through; only load flags are sticky
  assign status_w = {2'h0, sns.adapter_sense_pin, loads_q, short_w, overheat_q, sns.charge_done};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_prev_q <= '0;
      loads_q   <= '0;
      int_cnt_q <= '0;
      int_n_q   <= 1'b1;
    end else begin
      ev_prev_q <= ev_now_w;
      // A new edge in the read cycle survives the clear
      loads_q   <= ev_edge_w[3:2] | (loads_q & {2{~status_clr_w}});
      int_cnt_q <= int_cnt_d;
      int_n_q   <= ~((int_cnt_q != '0) | short_int_w);
    end
  end

  assign int_n = int_n_q;

  // ---------------------------------------------------------------
  // I2C slave
  // ---------------------------------------------------------------
  chi_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic       ack_q;
  logic       mnack_q;
  logic       sda_oe_q;
  logic       stretch_q;
  logic [7:0] shift_q;
  logic [7:0] rd_q;
  logic [7:0] ptr_q;
  logic       byte_end_w;
  logic       addr_hit_w;
  logic [7:0] rd_data_w;
  logic       rd_load_w;
  logic       buf_in_ready;
  chi_wr_s    buf_in_w;

  assign byte_end_w = ~ack_q & (bit_cnt_q == 4'h8);
  assign addr_hit_w = shift_q[7:1] == SLAVE_ADDR;
  assign rd_data_w  = (ptr_q == REG_STATUS) ? status_w :
                      addr_ok(ptr_q) ? regs_q[ptr_q[IW-1:0]] : 8'h00;
  assign rd_load_w  = ~ce_n_s & ~start_w & ~stop_w & scl_fall_w & ack_q &
                      (state_q == I2C_RDAT) & ~mnack_q;
  assign status_clr_w = rd_load_w & (ptr_q == REG_STATUS);
  assign buf_in_w   = '{addr: ptr_q, data: shift_q};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= I2C_IDLE;
      bit_cnt_q <= '0;
      ack_q     <= 1'b0;
      mnack_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
      stretch_q <= 1'b0;
      shift_q   <= '0;
      rd_q      <= '0;
      ptr_q     <= '0;
    end else if (ce_n_s || stop_w) begin
      state_q   <= I2C_IDLE;
      ack_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
      stretch_q <= 1'b0;
    end else if (start_w) begin
      state_q   <= I2C_ADDR;
      bit_cnt_q <= '0;
      ack_q     <= 1'b0;
      mnack_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
      stretch_q <= 1'b0;
    end else if (stretch_q) begin
      if (buf_in_ready) begin
        stretch_q <= 1'b0;
        ack_q     <= 1'b1;
        sda_oe_q  <= 1'b1;
        ptr_q     <= ptr_q + 8'h01;
      end
    end else if (scl_rise_w && state_q != I2C_IDLE) begin
      if (!ack_q) begin
        shift_q   <= {shift_q[6:0], sda_s};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (state_q == I2C_RDAT) begin
        mnack_q <= sda_s;
      end
    end else if (scl_fall_w && state_q != I2C_IDLE) begin
      if (byte_end_w) begin
        bit_cnt_q <= '0;
        case (state_q)
          I2C_ADDR: begin
            if (addr_hit_w) begin
              ack_q    <= 1'b1;
              sda_oe_q <= 1'b1;
              state_q  <= shift_q[0] ? I2C_RDAT : I2C_REG;
            end else begin
              state_q <= I2C_IDLE;
            end
          end
          I2C_REG: begin
            if (addr_ok(shift_q)) begin
              ptr_q    <= shift_q;
              ack_q    <= 1'b1;
              sda_oe_q <= 1'b1;
              state_q  <= I2C_WDAT;
            end else begin
              state_q <= I2C_IDLE;
            end
          end
          I2C_WDAT: begin
            if (addr_ok(ptr_q)) begin
              stretch_q <= 1'b1;
            end else begin
              state_q <= I2C_IDLE;
            end
          end
          I2C_RDAT: begin
            ack_q    <= 1'b1;
            sda_oe_q <= 1'b0;
          end
          default: state_q <= I2C_IDLE;
        endcase
      end else if (ack_q) begin
        ack_q <= 1'b0;
        if (rd_load_w) begin
          rd_q     <= rd_data_w;
          sda_oe_q <= ~rd_data_w[7];
          ptr_q    <= ptr_q + 8'h01;
        end else begin
          sda_oe_q <= 1'b0;
          if (mnack_q) begin
            state_q <= I2C_IDLE;
          end
        end
      end else if (state_q == I2C_RDAT) begin
        rd_q     <= {rd_q[6:0], 1'b0};
        sda_oe_q <= ~rd_q[6];
      end
    end
  end

  // Only low is ever driven on either line
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = stretch_q;
  assign sda_oe  = sda_oe_q;

  // Two entries decouple the I2C byte rate from a slow consumer
  chi_buf2 #(
    .WIDTH ($bits(chi_wr_s)),
    .DEPTH (BUF_DEPTH)
  ) u_wr_buf (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (stretch_q),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_w),
    .out_valid (reg_wr_valid),
    .out_ready (reg_wr_ready),
    .out_data  (reg_wr)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_standby;
    !ce_n_s && halt_s |=> !switch_enable && standby;
  endproperty
  a_standby: assert property (p_standby) else $error("switching in standby");

  property p_shutdown;
    ce_n_s |=> state_q == I2C_IDLE && !sda_oe && !scl_oe;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("I2C active in shutdown");

  property p_bus_ovp;
    discharge_w && !ctrl_w[CTRL_OVP_OFF] && sns.bus_over |=> !switch_enable;
  endproperty
  a_bus_ovp: assert property (p_bus_ovp) else $error("bus overvoltage ignored");

  property p_bat_ovp;
    sns.bat_over |=> !switch_enable;
  endproperty
  a_bat_ovp: assert property (p_bat_ovp) else $error("battery overvoltage ignored");

  property p_fold;
    fold_w |=> bus_current_limit_pct == FOLD_BUS_PCT && battery_current_limit_pct == FOLD_BAT_PCT;
  endproperty
  a_fold: assert property (p_fold) else $error("limits not folded back");

  property p_heat;
    sns.temp_high |=> overheat_q ##1 !switch_enable;
  endproperty
  a_heat: assert property (p_heat) else $error("overheat did not stop switching");

  property p_addr_miss;
    !ce_n_s && scl_fall_w && state_q == I2C_ADDR && byte_end_w && !addr_hit_w
      |=> state_q == I2C_IDLE && !sda_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

  property p_reg_nack;
    !ce_n_s && scl_fall_w && state_q == I2C_REG && byte_end_w && !addr_ok(shift_q)
      |=> state_q == I2C_IDLE && !sda_oe;
  endproperty
  a_reg_nack: assert property (p_reg_nack) else $error("undefined register acknowledged");

  property p_pulse;
    evt_w |=> int_cnt_q == CW'(PULSE_CYCLES) ##1 !int_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt pulse not started");

  property p_short_int;
    short_int_w |=> !int_n;
  endproperty
  a_short_int: assert property (p_short_int) else $error("bus short not held on interrupt");

  property p_mask;
    (&mask_w[STS_ADAPTER:0]) && int_cnt_q == '0 |=> int_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked flag raised interrupt");

  property p_stretch;
    stretch_q && !buf_in_ready && !ce_n_s && !stop_w && !start_w |=> scl_oe && !ack_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock released while buffer full");

endmodule

`default_nettype wire

// *** tb/chi_i2c_master.sv ***
/*
  I2C master model standing in for the host controller.
  Assumes pull-ups on both lines; one bit takes 160 ns.
*/
`default_nettype none
module chi_i2c_master (
  // Clock used to poll a stretched SCL
  input  wire logic ref_clk,
  // Slave pull-downs
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Wired line levels
  output logic      scl_in,
  output logic      sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  // Released lines float to the pull-up level
  assign scl_in = scl_m & ~scl_oe;
  assign sda_in = sda_m & ~sda_oe;
  // Release SDA and SCL, then pull SDA low while SCL is high for a (repeated) START
  task automatic start();
    #50 sda_m = 1'b1;
    #50 scl_m = 1'b1;
    #50 sda_m = 1'b0;
    #50 scl_m = 1'b0;
  endtask
  task automatic stop();
    #50 sda_m = 1'b0;
    #50 scl_m = 1'b1;
    #50 sda_m = 1'b1;
    #50;
  endtask
  task automatic bit_x(input logic b, output logic r);
    #50 sda_m = b;
    #50 scl_m = 1'b1;
    #1;
    while (scl_in !== 1'b1) @(posedge ref_clk);
    #59 r = sda_in;
    scl_m = 1'b0;
  endtask
  // Send tx and sample the line; a read sends all ones to leave SDA free
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], r);
      rx[i] = r;
    end
    bit_x(mack, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_chi_charger_ctrl.sv ***
/*
  Self-checking bench of the charger host-control block.
  Assumes the master model of chi_i2c_master.sv on the bus.
*/
`default_nettype none
module tb_chi_charger_ctrl;
  import chi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce_n = 1'b1;
  logic       halt = 1'b0;
  logic       wr_ready = 1'b1;
  chi_sense_s sense = '0;
  logic       scl, sda, scl_oe, sda_oe, int_n, wr_valid, sw_en, stby, shdn, dis;
  chi_wr_s    wr_word;
  logic [6:0] bus_pct, bat_pct;
  int         n_errors = 0;
  int         comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  chi_charger_ctrl #(.PULSE_CYCLES(20)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .chip_enable_n(ce_n),
    .power_stage_halt(halt), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .int_n(int_n), .sense(sense), .reg_wr_valid(wr_valid), .reg_wr(wr_word),
    .reg_wr_ready(wr_ready), .switch_enable(sw_en), .standby(stby), .shutdown(shdn),
    .discharge_enable(dis), .bus_current_limit_pct(bus_pct), .battery_current_limit_pct(bat_pct));
  chi_i2c_master m (.ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl), .sda_in(sda));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // A refused byte ends the transfer at once
  task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic a);
    logic [7:0] x;
    m.start();
    m.xfer(8'hE8, 1'b1, x, a);
    if (a) m.xfer(ra, 1'b1, x, a);
    if (a) m.xfer(d, 1'b1, x, a);
    m.stop();
    tick(2);
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] v);
    logic a;
    m.start();
    m.xfer(8'hE8, 1'b1, v, a);
    m.xfer(ra, 1'b1, v, a);
    m.start();
    m.xfer(8'hE9, 1'b1, v, a);
    m.xfer(8'hFF, 1'b1, v, a);
    m.stop();
    tick(2);
  endtask
  task automatic pulse(input string what, input logic [7:0] exp);
    int n = 0;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (int_n === 1'b0) n++;
    end
    chk(what, 8'(n), exp);
  endtask
  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_mode();
    logic a;
    chk("shutdown", shdn, 1);
    wr(8'h03, 8'h11, a);
    chk("ack off", a, 0);
    ce_n = 1'b0;
    tick(8);
    chk("switch", sw_en, 1);
    halt = 1'b1;
    tick(8);
    chk("standby", stby, 1);
    chk("halted", sw_en, 0);
    wr(8'h03, 8'h11, a);
    chk("ack standby", a, 1);
    halt = 1'b0;
    $display("mode done");
  endtask
  task automatic t_addr();
    logic a;
    logic [7:0] x;
    m.start();
    m.xfer(8'hEA, 1'b1, x, a);
    m.stop();
    chk("ack other", a, 0);
    wr(8'h09, 8'h11, a);
    chk("ack undef", a, 0);
    $display("addr done");
  endtask
  task automatic t_multi();
    logic a;
    logic [7:0] x;
    logic [7:0] dat [3] = '{8'hA5, 8'h5A, 8'hC3};
    wr_ready = 1'b0;
    fork
      begin
        m.start();
        m.xfer(8'hE8, 1'b1, x, a);
        m.xfer(8'h03, 1'b1, x, a);
        foreach (dat[i]) m.xfer(dat[i], 1'b1, x, a);
        m.stop();
      end
      begin
        tick(500);
        chk("stretch", scl_oe, 1);
        chk("valid", wr_valid, 1);
        chk("word", wr_word.data, 8'hA5);
        wr_ready = 1'b1;
      end
    join
    m.start();
    m.xfer(8'hE8, 1'b1, x, a);
    m.xfer(8'h03, 1'b1, x, a);
    m.start();
    m.xfer(8'hE9, 1'b1, x, a);
    foreach (dat[i]) begin
      m.xfer(8'hFF, i == 2, x, a);
      chk("readback", x, dat[i]);
    end
    m.stop();
    tick(2);
    $display("multi done");
  endtask
  task automatic t_irq();
    logic a;
    logic [7:0] v;
    sense.load_a = 1'b1;
    pulse("load rise", 20);
    sense.load_a = 1'b0;
    pulse("load fall", 0);
    rd(REG_STATUS, v);
    chk("sticky", v, 8'h08);
    rd(REG_STATUS, v);
    chk("cleared", v, 8'h00);
    for (int i = 0; i < 2; i++) begin
      sense.charge_done = ~sense.charge_done;
      pulse("done edge", 20);
    end
    wr(REG_MASK, 8'h01, a);
    sense.charge_done = 1'b1;
    pulse("masked", 0);
    rd(REG_STATUS, v);
    chk("live", v, 8'h01);
    wr(REG_CTRL, 8'h01, a);
    chk("discharge", dis, 1);
    sense.bus_low = 1'b1;
    tick(40);
    chk("continuous", int_n, 0);
    chk("bus fold", bus_pct, 8'd22);
    chk("bat fold", bat_pct, 8'd10);
    sense.bus_low = 1'b0;
    tick(8);
    chk("int idle", int_n, 1);
    $display("irq done");
  endtask
  task automatic t_prot();
    logic a;
    sense.bus_over = 1'b1;
    tick(8);
    chk("bus ovp", sw_en, 0);
    wr(REG_CTRL, 8'h03, a);
    chk("guard off", sw_en, 1);
    sense.bus_over = 1'b0;
    sense.bat_over = 1'b1;
    tick(8);
    chk("bat ovp", sw_en, 0);
    sense.bat_over = 1'b0;
    sense.temp_high = 1'b1;
    tick(8);
    sense.temp_high = 1'b0;
    tick(8);
    chk("overheat", sw_en, 0);
    sense.temp_cool = 1'b1;
    tick(8);
    chk("recovered", sw_en, 1);
    $display("prot done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    tick(4);
    t_mode();
    t_addr();
    t_multi();
    t_irq();
    t_prot();
    summarize();
  end
  initial begin
    #1_500_000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
